// *** design/timer8_defs.vh ***
`ifndef TIMER8_DEFS_VH
`define TIMER8_DEFS_VH

// ********************************
// register offsets
// ********************************
`define ADDR_CONTROL 3'h0
`define ADDR_COMPARE 3'h1
`define ADDR_COUNT 3'h2
`define ADDR_STATUS 3'h3
`define ADDR_PIN_DIR 3'h4

// ********************************
// control field positions
// ********************************
`define CTL_MODE_LO 0
`define CTL_MODE_HI 1
`define CTL_ACT_LO 2
`define CTL_ACT_HI 3
`define CTL_CLK_LO 4
`define CTL_CLK_HI 6
`define CTL_FORCE 7

// ********************************
// status field positions
// ********************************
`define STS_COMPARE 0
`define STS_OVERFLOW 1
`define STS_UP 2

// ********************************
// modes and actions
// ********************************
`define MODE_NORMAL 2'h0
`define MODE_PHASE 2'h1
`define MODE_CTC 2'h2
`define MODE_FAST 2'h3
`define ACT_OFF 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3

// ********************************
// counter limits and reset values
// ********************************
`define CNT_MAX 8'hFF
`define CNT_BOTTOM 8'h00
`define CNT_ONE 8'h01
`define RST_CONTROL 8'h00
`define RST_COMPARE 8'h00
`define RST_COUNT 8'h00
`define RST_DIR 1'h0

// ********************************
// prescale selects and divider masks
// ********************************
`define CLK_STOP 3'h0
`define CLK_DIV1 3'h1
`define CLK_DIV8 3'h2
`define CLK_DIV64 3'h3
`define CLK_DIV256 3'h4
`define CLK_DIV1024 3'h5
`define MASK_DIV8 10'h007
`define MASK_DIV64 10'h03F
`define MASK_DIV256 10'h0FF
`define MASK_DIV1024 10'h3FF

`endif

// *** design/timer8_prescaler.v ***
`timescale 1ns/1ns
`include "timer8_defs.vh"

module timer8_prescaler (
  input wire clk_sys,
  input wire reset,
  input wire [2:0] clock_select,
  output reg tick
);

  reg [9:0] div_ff;
  wire [9:0] nxt_div;

  // free running, so a select change takes effect mid-period
  assign nxt_div = div_ff + 10'h001;

  always @(posedge clk_sys) begin
    if (reset) begin
      div_ff <= 10'h000;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // external clock selects have no source here and stop the timer
  always @* begin
    tick = 1'b0;
    case (clock_select)
      `CLK_DIV1: tick = 1'b1;
      `CLK_DIV8: tick = ((div_ff & `MASK_DIV8) == `MASK_DIV8);
      `CLK_DIV64: tick = ((div_ff & `MASK_DIV64) == `MASK_DIV64);
      `CLK_DIV256: tick = ((div_ff & `MASK_DIV256) == `MASK_DIV256);
      `CLK_DIV1024: tick = (div_ff == `MASK_DIV1024);
      default: tick = 1'b0;
    endcase
  end

endmodule // timer8_prescaler

// *** design/timer8_waveform_modes.v ***
`timescale 1ns/1ns
`include "timer8_defs.vh"

module timer8_waveform_modes (
  input wire clk_sys,
  input wire reset,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_ff,
  output reg waveform_output_ff,
  output reg waveform_oe_ff,
  output reg compare_match_flag_ff,
  output reg overflow_flag_ff
);

  // ********************************
  // software registers
  // ********************************
  reg [1:0] waveform_mode_select_ff;
  reg [1:0] output_action_select_ff;
  reg [2:0] clock_select_ff;
  reg pin_dir_ff;
  reg [7:0] compare_buf_ff;
  reg [7:0] compare_value_ff;
  reg [7:0] count_value_ff;
  reg count_up_ff;
  reg match_block_ff;
  reg waveform_state_ff;

  reg [7:0] nxt_count;
  reg nxt_up;
  reg nxt_state;
  reg [7:0] nxt_compare;
  reg set_compare_flag;
  reg set_overflow_flag;

  wire tick;
  wire wr_control;
  wire wr_compare;
  wire wr_count;
  wire wr_status;
  wire wr_dir;
  wire force_cmp;
  wire is_pwm;
  wire at_max;
  wire at_bottom;
  wire match;
  wire top_ignore;
  wire up_result;
  wire down_result;

  assign wr_control = reg_wr && (reg_addr == `ADDR_CONTROL);
  assign wr_compare = reg_wr && (reg_addr == `ADDR_COMPARE);
  assign wr_count = reg_wr && (reg_addr == `ADDR_COUNT);
  assign wr_status = reg_wr && (reg_addr == `ADDR_STATUS);
  assign wr_dir = reg_wr && (reg_addr == `ADDR_PIN_DIR);

  // ********************************
  // timer clock enable
  // ********************************
  timer8_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .reset(reset),
    .clock_select(clock_select_ff),
    .tick(tick)
  );

  always @(posedge clk_sys) begin
    if (reset) begin
      waveform_mode_select_ff <= `MODE_NORMAL;
      output_action_select_ff <= `ACT_OFF;
      clock_select_ff <= `CLK_STOP;
      pin_dir_ff <= `RST_DIR;
    end else begin
      if (wr_control) begin
        waveform_mode_select_ff <= reg_wdata[`CTL_MODE_HI:`CTL_MODE_LO];
        output_action_select_ff <= reg_wdata[`CTL_ACT_HI:`CTL_ACT_LO];
        clock_select_ff <= reg_wdata[`CTL_CLK_HI:`CTL_CLK_LO];
      end
      if (wr_dir) begin
        pin_dir_ff <= reg_wdata[0];
      end
    end
  end

  // ********************************
  // compare decode
  // ********************************
  assign is_pwm = (waveform_mode_select_ff == `MODE_PHASE) ||
                  (waveform_mode_select_ff == `MODE_FAST);
  // force strobe only acts in the non-pwm modes
  assign force_cmp = wr_control && reg_wdata[`CTL_FORCE] && !is_pwm;
  assign at_max = (count_value_ff == `CNT_MAX);
  assign at_bottom = (count_value_ff == `CNT_BOTTOM);
  // a count write blocks the match of the next timer tick
  assign match = (count_value_ff == compare_value_ff) && !match_block_ff;
  assign top_ignore = is_pwm && output_action_select_ff[1] &&
                      (compare_value_ff == `CNT_MAX);
  assign up_result = output_action_select_ff[0];
  assign down_result = !output_action_select_ff[0];

  // ********************************
  // counter, direction and buffer
  // ********************************
  always @* begin
    nxt_count = count_value_ff;
    nxt_up = count_up_ff;
    nxt_compare = compare_value_ff;
    set_compare_flag = 1'b0;
    set_overflow_flag = 1'b0;
    if (!is_pwm) begin
      // buffer is bypassed, writes land at once
      nxt_compare = compare_buf_ff;
    end
    if (tick) begin
      set_compare_flag = match;
      case (waveform_mode_select_ff)
        `MODE_CTC: begin
          if (match) begin
            nxt_count = `CNT_BOTTOM;
          end else begin
            // a top below the count is only met after the wrap
            nxt_count = count_value_ff + `CNT_ONE;
          end
          set_overflow_flag = at_max;
        end
        `MODE_FAST: begin
          if (at_max) begin
            nxt_count = `CNT_BOTTOM;
            nxt_compare = compare_buf_ff;
          end else begin
            nxt_count = count_value_ff + `CNT_ONE;
          end
          set_overflow_flag = at_max;
        end
        `MODE_PHASE: begin
          if (count_up_ff) begin
            if (at_max) begin
              nxt_up = 1'b0;
              nxt_count = count_value_ff - `CNT_ONE;
            end else begin
              nxt_count = count_value_ff + `CNT_ONE;
            end
          end else begin
            if (at_bottom) begin
              nxt_up = 1'b1;
              nxt_count = count_value_ff + `CNT_ONE;
            end else begin
              nxt_count = count_value_ff - `CNT_ONE;
            end
          end
          // the buffer moves while the count sits at top
          if (at_max) begin
            nxt_compare = compare_buf_ff;
          end
          set_overflow_flag = at_bottom;
        end
        default: begin
          nxt_count = count_value_ff + `CNT_ONE;
          set_overflow_flag = at_max;
        end
      endcase
    end
  end

  // ********************************
  // waveform generator
  // ********************************
  always @* begin
    nxt_state = waveform_state_ff;
    if (force_cmp) begin
      case (output_action_select_ff)
        `ACT_TOGGLE: nxt_state = !waveform_state_ff;
        `ACT_CLEAR: nxt_state = 1'b0;
        `ACT_SET: nxt_state = 1'b1;
        default: nxt_state = waveform_state_ff;
      endcase
    end else if (tick) begin
      case (waveform_mode_select_ff)
        `MODE_FAST: begin
          if (output_action_select_ff[1]) begin
            if (at_max) begin
              // rollover to bottom restores the idle level
              nxt_state = !output_action_select_ff[0];
            end else if (match) begin
              nxt_state = output_action_select_ff[0];
            end
          end else if (output_action_select_ff[0] && match) begin
            nxt_state = !waveform_state_ff;
          end
        end
        `MODE_PHASE: begin
          if (output_action_select_ff[1]) begin
            if (at_max) begin
              // top level decides symmetry around bottom
              if (nxt_compare == `CNT_MAX) begin
                nxt_state = down_result;
              end else begin
                nxt_state = up_result;
              end
            end else if (match && !top_ignore) begin
              // bottom counts as up so a zero compare stays idle
              if (count_up_ff || at_bottom) begin
                nxt_state = up_result;
              end else begin
                nxt_state = down_result;
              end
            end
          end
        end
        default: begin
          if (match) begin
            case (output_action_select_ff)
              `ACT_TOGGLE: nxt_state = !waveform_state_ff;
              `ACT_CLEAR: nxt_state = 1'b0;
              `ACT_SET: nxt_state = 1'b1;
              default: nxt_state = waveform_state_ff;
            endcase
          end
        end
      endcase
    end
  end

  // ********************************
  // state registers
  // ********************************
  always @(posedge clk_sys) begin
    if (reset) begin
      count_value_ff <= `RST_COUNT;
      count_up_ff <= 1'b1;
      compare_buf_ff <= `RST_COMPARE;
      compare_value_ff <= `RST_COMPARE;
      match_block_ff <= 1'b0;
      waveform_state_ff <= 1'b0;
    end else begin
      compare_value_ff <= nxt_compare;
      waveform_state_ff <= nxt_state;
      count_up_ff <= nxt_up;
      if (wr_compare) begin
        compare_buf_ff <= reg_wdata;
      end
      // software write beats the tick on the count
      if (wr_count) begin
        count_value_ff <= reg_wdata;
        match_block_ff <= 1'b1;
      end else begin
        count_value_ff <= nxt_count;
        if (tick) begin
          match_block_ff <= 1'b0;
        end
      end
    end
  end

  // ********************************
  // flags, write one to clear
  // ********************************
  always @(posedge clk_sys) begin
    if (reset) begin
      compare_match_flag_ff <= 1'b0;
      overflow_flag_ff <= 1'b0;
    end else begin
      // a set in the clearing cycle wins
      if (set_compare_flag) begin
        compare_match_flag_ff <= 1'b1;
      end else if (wr_status && reg_wdata[`STS_COMPARE]) begin
        compare_match_flag_ff <= 1'b0;
      end
      if (set_overflow_flag) begin
        overflow_flag_ff <= 1'b1;
      end else if (wr_status && reg_wdata[`STS_OVERFLOW]) begin
        overflow_flag_ff <= 1'b0;
      end
    end
  end

  // ********************************
  // pin drive
  // ********************************
  always @(posedge clk_sys) begin
    if (reset) begin
      waveform_output_ff <= 1'b0;
      waveform_oe_ff <= 1'b0;
    end else begin
      // state keeps running while the pin is an input
      waveform_output_ff <= nxt_state;
      waveform_oe_ff <= pin_dir_ff &&
                        (output_action_select_ff != `ACT_OFF);
    end
  end

  // ********************************
  // read port
  // ********************************
  always @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `ADDR_CONTROL) begin
        reg_rdata_ff <= {1'b0, clock_select_ff, output_action_select_ff,
                         waveform_mode_select_ff};
      end else if (reg_addr == `ADDR_COMPARE) begin
        reg_rdata_ff <= compare_buf_ff;
      end else if (reg_addr == `ADDR_COUNT) begin
        reg_rdata_ff <= count_value_ff;
      end else if (reg_addr == `ADDR_STATUS) begin
        reg_rdata_ff <= {5'h00, count_up_ff, overflow_flag_ff,
                         compare_match_flag_ff};
      end else if (reg_addr == `ADDR_PIN_DIR) begin
        reg_rdata_ff <= {7'h00, pin_dir_ff};
      end else begin
        reg_rdata_ff <= 8'h00;
      end
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

endmodule // timer8_waveform_modes

// *** tb/timer8_waveform_modes_props.sv ***
`timescale 1ns/1ns
`include "timer8_defs.vh"
module timer8_waveform_modes_props (
  input wire clk_sys,
  input wire reset,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_ff,
  input wire waveform_output_ff,
  input wire waveform_oe_ff,
  input wire compare_match_flag_ff,
  input wire overflow_flag_ff
);
  // ****
  // shadow of software settings
  // ****
  reg [7:0] ctl_ff;
  reg [7:0] cmp_ff;
  reg [9:0] quiet_ff;
  wire clr_st = reg_wr && reg_addr == `ADDR_STATUS;
  always @(posedge clk_sys) begin
    if (reset) begin
      ctl_ff <= `RST_CONTROL;
      cmp_ff <= `RST_COMPARE;
      quiet_ff <= 10'h000;
    end else begin
      if (reg_wr && reg_addr == `ADDR_CONTROL)
        ctl_ff <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_COMPARE)
        cmp_ff <= reg_wdata;
      // 600 quiet cycles cover a wrap, a dual-slope period and buffer load
      if (reg_wr)
        quiet_ff <= 10'h000;
      else if (quiet_ff != 10'h258)
        quiet_ff <= quiet_ff + 10'h001;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_steady;
    quiet_ff == 10'h258 && ctl_ff[6:4] == `CLK_DIV1;
  endsequence
  sequence s_pwm_top;
    s_steady ##0 (ctl_ff[0] && ctl_ff[3] && cmp_ff == `CNT_MAX);
  endsequence
  property p_cmp_sticky;
    compare_match_flag_ff && !(clr_st && reg_wdata[0])
      |=> compare_match_flag_ff;
  endproperty
  a_cmp_sticky: assert property (p_cmp_sticky)
    else $error("compare flag dropped without clear");
  property p_ovf_sticky;
    overflow_flag_ff && !(clr_st && reg_wdata[1]) |=> overflow_flag_ff;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow flag dropped without clear");
  property p_pin_off;
    reg_wr && reg_addr == `ADDR_PIN_DIR && !reg_wdata[0]
      |-> ##[1:2] !waveform_oe_ff;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("pin still driven as input");
  property p_stopped;
    quiet_ff > 10'h002 && ctl_ff[6:4] == `CLK_STOP
      |-> $stable(overflow_flag_ff) && $stable(compare_match_flag_ff)
      && $stable(waveform_output_ff);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("state moved with timer stopped");
  property p_ctc_tog;
    s_steady ##0 (ctl_ff[3:0] == 4'h6 && cmp_ff == `CNT_BOTTOM)
      |-> waveform_output_ff != $past(waveform_output_ff)
      && compare_match_flag_ff;
  endproperty
  a_ctc_tog: assert property (p_ctc_tog)
    else $error("toggle at compare zero not every cycle");
  property p_ctc_ovf;
    s_steady ##0 (ctl_ff[1:0] == `MODE_CTC && cmp_ff != `CNT_MAX)
      |-> !$rose(overflow_flag_ff);
  endproperty
  a_ctc_ovf: assert property (p_ctc_ovf)
    else $error("overflow without reaching max");
  property p_pwm_top;
    s_pwm_top |-> waveform_output_ff == !ctl_ff[2];
  endproperty
  a_pwm_top: assert property (p_pwm_top)
    else $error("top compare level wrong");
  property p_phase_bot;
    s_steady ##0 (ctl_ff[1:0] == `MODE_PHASE && ctl_ff[3]
      && cmp_ff == `CNT_BOTTOM) |-> waveform_output_ff == ctl_ff[2];
  endproperty
  a_phase_bot: assert property (p_phase_bot)
    else $error("bottom compare level wrong");
endmodule // timer8_waveform_modes_props

bind timer8_waveform_modes timer8_waveform_modes_props props (
  .clk_sys(clk_sys),
  .reset(reset),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff),
  .waveform_output_ff(waveform_output_ff),
  .waveform_oe_ff(waveform_oe_ff),
  .compare_match_flag_ff(compare_match_flag_ff),
  .overflow_flag_ff(overflow_flag_ff)
);

// *** tb/port_pin_load.sv ***
`timescale 1ns/1ns
module port_pin_load (
  input wire clk_sys,
  input wire drive_value,
  input wire drive_enable,
  output wire pin_level
);
  // undriven pin shows the opposite level so a stale value cannot pass
  assign pin_level = drive_enable ? drive_value : ~drive_value;
endmodule // port_pin_load

// *** tb/timer8_waveform_modes_test.sv ***
`timescale 1ns/1ns
`include "timer8_defs.vh"
module timer8_waveform_modes_test;
  reg clk_sys;
  reg reset;
  reg [2:0] reg_addr;
  reg [7:0] reg_wdata;
  reg reg_wr, reg_rd;
  wire [7:0] reg_rdata_ff;
  wire waveform_output_ff, waveform_oe_ff, pin_level;
  wire compare_match_flag_ff, overflow_flag_ff;
  integer miscompares = 0;
  integer num_checks = 0;
  integer n;
  integer i;

  timer8_waveform_modes uut (
    .clk_sys(clk_sys),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff),
    .waveform_output_ff(waveform_output_ff),
    .waveform_oe_ff(waveform_oe_ff),
    .compare_match_flag_ff(compare_match_flag_ff),
    .overflow_flag_ff(overflow_flag_ff)
  );
  port_pin_load load (
    .clk_sys(clk_sys),
    .drive_value(waveform_output_ff),
    .drive_enable(waveform_oe_ff),
    .pin_level(pin_level)
  );

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ****
  // bus and measurement tasks
  // ****
  task check(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
    end
  endtask
  task rd(input [2:0] a, input [7:0] exp);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1;
      check({8'h00, reg_rdata_ff}, {8'h00, exp});
    end
  endtask
  // cycles until the output changes, 1200 means none seen
  task edge_wait(output integer cnt);
    reg v;
    begin
      v = waveform_output_ff;
      cnt = 0;
      while (waveform_output_ff === v && cnt < 1200) begin
        @(posedge clk_sys);
        #1;
        cnt = cnt + 1;
      end
    end
  endtask
  // high time; x is the steady level when hi is 04B0, else overflow flag
  task pwm(input [7:0] ctl, input [7:0] cmp, input [15:0] hi, input x);
    begin
      wr(`ADDR_COMPARE, cmp);
      wr(`ADDR_CONTROL, ctl);
      // long settle: buffered compare loads only at top or bottom
      repeat (600) @(posedge clk_sys);
      #1;
      edge_wait(n);
      if (n < 1200) begin
        if (waveform_output_ff !== 1'h1)
          edge_wait(n);
        edge_wait(n);
      end
      check(n[15:0], hi);
      if (n >= 1200)
        check({15'h0000, waveform_output_ff}, {15'h0000, x});
      else begin
        wr(`ADDR_STATUS, 8'h03);
        repeat (520) @(posedge clk_sys);
        #1;
        check({15'h0000, compare_match_flag_ff}, 16'h0001);
        check({15'h0000, overflow_flag_ff}, {15'h0000, x});
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // ****
  // test sequence
  // ****
  initial begin
    reset = 1'h1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'h0;
    // direction bit reads as up after reset
    for (i = 0; i < 6; i = i + 1)
      rd(i[2:0], (i == 3) ? 8'h04 : 8'h00);
    wr(`ADDR_CONTROL, 8'h8E);
    rd(`ADDR_CONTROL, 8'h0E);
    // force now uses the stored set action; pin still an input
    wr(`ADDR_CONTROL, 8'h8E);
    #1;
    check({15'h0000, waveform_output_ff}, 16'h0001);
    check({15'h0000, pin_level}, 16'h0000);
    wr(`ADDR_PIN_DIR, 8'h01);
    wr(`ADDR_COUNT, 8'h20);
    wr(`ADDR_COMPARE, 8'h10);
    wr(`ADDR_STATUS, 8'h03);
    rd(`ADDR_COUNT, 8'h20);
    wr(`ADDR_CONTROL, 8'h16);
    n = 0;
    while (compare_match_flag_ff !== 1'h1 && n < 400) begin
      @(posedge clk_sys);
      #1;
      n = n + 1;
    end
    check({15'h0000, overflow_flag_ff}, 16'h0001);
    check(n[15:0], 16'h00F1);
    pwm(8'h16, 8'h04, 16'h0005, 1'h0);
    pwm(8'h16, 8'h00, 16'h0001, 1'h0);
    pwm(8'h36, 8'h00, 16'h0040, 1'h0);
    pwm(8'h46, 8'h00, 16'h0100, 1'h0);
    pwm(8'h26, 8'h04, 16'h0028, 1'h0);
    pwm(8'h1B, 8'h40, 16'h0041, 1'h1);
    check({15'h0000, waveform_oe_ff}, 16'h0001);
    check({15'h0000, pin_level}, {15'h0000, waveform_output_ff});
    pwm(8'h1F, 8'h40, 16'h00BF, 1'h1);
    pwm(8'h1B, 8'h00, 16'h0001, 1'h1);
    pwm(8'h17, 8'h40, 16'h0100, 1'h1);
    pwm(8'h19, 8'h40, 16'h0080, 1'h1);
    pwm(8'h1D, 8'h40, 16'h017E, 1'h1);
    pwm(8'h1B, 8'hFF, 16'h04B0, 1'h1);
    pwm(8'h19, 8'h00, 16'h04B0, 1'h0);
    pwm(8'h19, 8'hFF, 16'h04B0, 1'h1);
    pwm(8'h1D, 8'hFF, 16'h04B0, 1'h0);
    wr(`ADDR_PIN_DIR, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    check({15'h0000, waveform_oe_ff}, 16'h0000);
    check({15'h0000, pin_level}, {15'h0000, !waveform_output_ff});
    finish_test;
  end

  initial begin
    #800000;
    miscompares = miscompares + 1;
    finish_test;
  end
endmodule // timer8_waveform_modes_test
